// ### design/utc_core.sv
// serial transmit/receive core: baud ticks, transmitter, receiver, flags
`timescale 1ns/1ns
module utc_core #(
  parameter int DIV_W = 8
) (
  input  wire logic             clock,
  input  wire logic             reset_n,
  input  wire logic             serial_func_en,
  input  wire logic             tx_enable,
  input  wire logic             rx_enable,
  input  wire logic             word_len_sel,
  input  wire logic             parity_en,
  input  wire logic             parity_type_sel,
  input  wire logic             stop_count_sel,
  input  wire logic             tx_break_ctrl,
  input  wire logic             tx_ninth_bit,
  input  wire logic             tx_empty_irq_en,
  input  wire logic             rx_irq_en,
  input  wire logic [DIV_W-1:0] baud_divisor,
  input  wire logic             status_rd,
  input  wire logic             tx_wr,
  input  wire logic [7:0]       tx_wdata,
  input  wire logic             rx_rd,
  output logic      [7:0]       rx_data,
  output logic                  rx_ninth_bit,
  output logic                  tx_buf_empty_flag,
  output logic                  tx_idle_flag,
  output logic                  rx_avail_flag,
  output logic                  rx_idle_flag,
  output logic                  overrun_flag,
  output logic                  framing_err_flag,
  output logic                  parity_err_flag,
  output logic                  noise_flag,
  output logic                  tx_irq,
  output logic                  rx_irq,
  input  wire logic             rx_pin,
  output logic                  tx_pin_o,
  output logic                  tx_pin_oe
);

  // *****************************************************************
  // parameter check
  // *****************************************************************
  if (DIV_W < 1 || DIV_W > 16) begin : g_bad_div
    $error("utc_core: DIV_W out of range");
  end

  // *****************************************************************
  // state
  // *****************************************************************
  typedef struct packed {
    logic [DIV_W-1:0]         div_cnt;
    logic                     status_seen;
    utc_pkg::utc_tx_st_t      tx_st;
    logic [3:0]               tx_tick;
    logic [3:0]               tx_bit;
    logic                     tx_brk;
    logic [8:0]               tx_sh;
    logic [8:0]               tx_buf;
    logic                     tx_pend;
    logic                     tx_line;
    logic                     tx_empty;
    logic                     tx_idle;
    utc_pkg::utc_rx_st_t      rx_st;
    logic [3:0]               rx_tick;
    logic [3:0]               rx_bit;
    logic [1:0]               rx_votes;
    logic                     rx_prev;
    logic                     rx_noisy;
    logic [8:0]               rx_sh;
    logic                     rx_idle;
    logic [1:0][8:0]          fifo;
    logic [1:0]               rx_cnt;
    logic                     ovr;
    logic                     fe;
    logic                     pe;
    logic                     nf;
    logic                     rx_irq;
  } utc_state_t;
  utc_state_t s_r;
  utc_state_t s_nxt;
  // expected parity over the data bits below the parity position
  function automatic logic par_of(input logic [8:0] w, input logic nine, input logic odd);
    logic p;
    p = nine ? ^w[7:0] : ^w[6:0];
    return p ^ odd;
  endfunction
  // word as it goes on the line, parity in the top position when enabled
  function automatic logic [8:0] build_word(input logic [8:0] d, input logic nine, input logic pen,
                                            input logic odd);
    logic [8:0] w;
    w = nine ? d : {1'b0, d[7:0]};
    if (pen && nine) begin
      w[8] = par_of(d, 1'b1, odd);
    end else if (pen) begin
      w[7] = par_of(d, 1'b0, odd);
    end
    return w;
  endfunction
  logic       tick;
  logic       tx_end;
  logic       wr_ok;
  logic       rd_ok;
  logic [3:0] nbits;
  logic [1:0] votes;
  logic       maj;
  logic [8:0] rword;

  // *****************************************************************
  // next state
  // *****************************************************************
  always_comb begin
    s_nxt        = s_r;
    s_nxt.rx_irq = 1'b0;
    tick         = (s_r.div_cnt == '0);
    s_nxt.div_cnt = tick ? baud_divisor : s_r.div_cnt - 1'b1;
    nbits        = word_len_sel ? utc_pkg::BITS_LONG : utc_pkg::BITS_SHORT;
    tx_end       = tick && (s_r.tx_tick == utc_pkg::TICK_LAST);
    votes        = s_r.rx_votes + {1'b0, rx_pin};
    maj          = (votes >= 2'd2);
    rword        = word_len_sel ? s_r.rx_sh : {1'b0, s_r.rx_sh[8:1]};
    // software access sequences: a status access arms the next write or read
    wr_ok = tx_wr && s_r.status_seen && s_r.tx_empty;
    rd_ok = rx_rd && s_r.status_seen && (s_r.rx_cnt != 2'd0);
    if (status_rd) begin
      s_nxt.status_seen = 1'b1;
    end else if (tx_wr || rx_rd) begin
      s_nxt.status_seen = 1'b0;
    end

    // ***************************************************************
    // transmitter
    // ***************************************************************
    if (wr_ok) begin
      s_nxt.tx_empty = 1'b0;
      s_nxt.tx_idle  = 1'b0;
      s_nxt.tx_buf   = build_word({tx_ninth_bit, tx_wdata}, word_len_sel, parity_en, parity_type_sel);
      s_nxt.tx_pend  = 1'b1;
    end
    if (!tx_enable) begin
      s_nxt.tx_st   = utc_pkg::TX_IDLE;
      s_nxt.tx_tick = 4'h0;
      s_nxt.tx_bit  = 4'h0;
      s_nxt.tx_brk  = 1'b0;
    end else begin
      if (s_r.tx_st != utc_pkg::TX_IDLE && tick) begin
        s_nxt.tx_tick = s_r.tx_tick + 4'h1;
      end
      case (s_r.tx_st)
        utc_pkg::TX_IDLE: begin
          // a write while idle goes straight to the shifter, so room reappears at once
          if (s_nxt.tx_pend && (wr_ok || tick)) begin
            s_nxt.tx_sh    = s_nxt.tx_buf;
            s_nxt.tx_pend  = 1'b0;
            s_nxt.tx_empty = 1'b1;
            s_nxt.tx_brk   = 1'b0;
            s_nxt.tx_st    = utc_pkg::TX_START;
            s_nxt.tx_tick  = 4'h0;
          end else if (tx_break_ctrl && tick) begin
            s_nxt.tx_brk   = 1'b1;
            s_nxt.tx_st    = utc_pkg::TX_START;
            s_nxt.tx_tick  = 4'h0;
          end
        end
        utc_pkg::TX_START: begin
          if (tx_end) begin
            s_nxt.tx_bit = 4'h0;
            s_nxt.tx_st  = s_r.tx_brk ? utc_pkg::TX_BRK : utc_pkg::TX_DATA;
          end
        end
        utc_pkg::TX_DATA: begin
          if (tx_end) begin
            s_nxt.tx_sh  = {1'b0, s_r.tx_sh[8:1]};
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            if (s_r.tx_bit == nbits - 4'h1) begin
              s_nxt.tx_bit = 4'h0;
              s_nxt.tx_st  = utc_pkg::TX_STOP;
            end
          end
        end
        utc_pkg::TX_BRK: begin
          if (tx_end) begin
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            if (s_r.tx_bit == utc_pkg::BREAK_LAST) begin
              s_nxt.tx_bit = 4'h0;
              if (!tx_break_ctrl) begin
                s_nxt.tx_st = utc_pkg::TX_STOP;
              end
            end
          end
        end
        utc_pkg::TX_STOP: begin
          if (tx_end) begin
            s_nxt.tx_bit = s_r.tx_bit + 4'h1;
            if (s_r.tx_bit == {3'h0, stop_count_sel}) begin
              s_nxt.tx_idle = 1'b1;
              s_nxt.tx_bit  = 4'h0;
              s_nxt.tx_brk  = 1'b0;
              s_nxt.tx_st   = utc_pkg::TX_IDLE;
              if (s_nxt.tx_pend) begin
                s_nxt.tx_sh    = s_nxt.tx_buf;
                s_nxt.tx_pend  = 1'b0;
                s_nxt.tx_empty = 1'b1;
                s_nxt.tx_st    = utc_pkg::TX_START;
              end
            end
          end
        end
        default: s_nxt.tx_st = utc_pkg::TX_IDLE;
      endcase
    end
    // line level registered from the next state
    case (s_nxt.tx_st)
      utc_pkg::TX_START: s_nxt.tx_line = 1'b0;
      utc_pkg::TX_BRK:   s_nxt.tx_line = 1'b0;
      utc_pkg::TX_DATA:  s_nxt.tx_line = s_nxt.tx_sh[0];
      default:           s_nxt.tx_line = utc_pkg::LINE_IDLE;
    endcase

    // ***************************************************************
    // receive buffer read, done before any push so a full buffer can take a word
    // ***************************************************************
    if (rd_ok) begin
      s_nxt.fifo[0] = s_r.fifo[1];
      s_nxt.rx_cnt  = s_r.rx_cnt - 2'd1;
      s_nxt.ovr     = 1'b0;
      s_nxt.fe      = 1'b0;
      s_nxt.pe      = 1'b0;
      s_nxt.nf      = 1'b0;
    end

    // ***************************************************************
    // receiver
    // ***************************************************************
    if (!rx_enable) begin
      s_nxt.rx_st   = utc_pkg::RX_HUNT;
      s_nxt.rx_idle = 1'b1;
      s_nxt.rx_prev = 1'b1;
    end else if (tick) begin
      s_nxt.rx_prev = rx_pin;
      if (s_r.rx_st != utc_pkg::RX_HUNT && s_r.rx_st != utc_pkg::RX_WAIT) begin
        s_nxt.rx_tick = s_r.rx_tick + 4'h1;
        if (s_r.rx_tick >= utc_pkg::VOTE_FIRST && s_r.rx_tick < utc_pkg::VOTE_LAST) begin
          s_nxt.rx_votes = votes;
        end else if (s_r.rx_tick == utc_pkg::VOTE_LAST) begin
          s_nxt.rx_votes = 2'd0;
          if (votes == 2'd1 || votes == 2'd2) begin
            s_nxt.rx_noisy = 1'b1;
          end
        end
      end
      case (s_r.rx_st)
        utc_pkg::RX_HUNT: begin
          if (!rx_pin && s_r.rx_prev) begin
            s_nxt.rx_st    = utc_pkg::RX_START;
            s_nxt.rx_tick  = 4'h1;
            s_nxt.rx_bit   = 4'h0;
            s_nxt.rx_votes = 2'd0;
            s_nxt.rx_noisy = 1'b0;
            s_nxt.rx_idle  = 1'b0;
          end
        end
        utc_pkg::RX_START: begin
          if (s_r.rx_tick == utc_pkg::VOTE_LAST && maj) begin
            // glitch, not a start bit
            s_nxt.rx_st   = utc_pkg::RX_HUNT;
            s_nxt.rx_idle = 1'b1;
          end else if (s_r.rx_tick == utc_pkg::TICK_LAST) begin
            s_nxt.rx_st = utc_pkg::RX_DATA;
          end
        end
        utc_pkg::RX_DATA: begin
          if (s_r.rx_tick == utc_pkg::VOTE_LAST) begin
            s_nxt.rx_sh  = {maj, s_r.rx_sh[8:1]};
            s_nxt.rx_bit = s_r.rx_bit + 4'h1;
          end else if (s_r.rx_tick == utc_pkg::TICK_LAST && s_r.rx_bit == nbits) begin
            s_nxt.rx_st = utc_pkg::RX_STOP;
          end
        end
        utc_pkg::RX_STOP: begin
          if (s_r.rx_tick == utc_pkg::VOTE_LAST) begin
            s_nxt.rx_idle = 1'b1;
            s_nxt.rx_st   = maj ? utc_pkg::RX_HUNT : utc_pkg::RX_WAIT;
            s_nxt.rx_irq  = rx_irq_en;
            if (s_nxt.rx_cnt == 2'd2) begin
              s_nxt.ovr = 1'b1;
            end else begin
              // a break arrives as all-zero data with a low stop
              s_nxt.fifo[s_nxt.rx_cnt[0]] = rword;
              s_nxt.rx_cnt = s_nxt.rx_cnt + 2'd1;
              if (!maj) begin
                s_nxt.fe = 1'b1;
              end
              if (parity_en && (word_len_sel ? rword[8] : rword[7]) != par_of(rword, word_len_sel,
                                                                            parity_type_sel)) begin
                s_nxt.pe = 1'b1;
              end
              if (s_nxt.rx_noisy || votes == 2'd1 || votes == 2'd2) begin
                s_nxt.nf = 1'b1;
              end
            end
          end
        end
        utc_pkg::RX_WAIT: begin
          // a line still held low is never taken as the next start
          if (rx_pin) begin
            s_nxt.rx_st   = utc_pkg::RX_HUNT;
            s_nxt.rx_prev = 1'b1;
          end
        end
        default: s_nxt.rx_st = utc_pkg::RX_HUNT;
      endcase
    end

    // ***************************************************************
    // function disabled: buffers emptied, flags to their rest values
    // ***************************************************************
    if (!serial_func_en) begin
      s_nxt.tx_st    = utc_pkg::TX_IDLE;
      s_nxt.tx_pend  = 1'b0;
      s_nxt.tx_brk   = 1'b0;
      s_nxt.tx_line  = utc_pkg::LINE_IDLE;
      s_nxt.tx_empty = utc_pkg::TX_EMPTY_RST;
      s_nxt.tx_idle  = utc_pkg::TX_IDLE_RST;
      s_nxt.rx_st    = utc_pkg::RX_HUNT;
      s_nxt.rx_idle  = utc_pkg::RX_IDLE_RST;
      s_nxt.rx_cnt   = 2'd0;
      s_nxt.ovr      = 1'b0;
      s_nxt.fe       = 1'b0;
      s_nxt.pe       = 1'b0;
      s_nxt.nf       = 1'b0;
      s_nxt.rx_irq   = 1'b0;
    end
  end

  // *****************************************************************
  // registers
  // *****************************************************************
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      s_r          <= '0;
      s_r.tx_line  <= utc_pkg::LINE_IDLE;
      s_r.tx_empty <= utc_pkg::TX_EMPTY_RST;
      s_r.tx_idle  <= utc_pkg::TX_IDLE_RST;
      s_r.rx_idle  <= utc_pkg::RX_IDLE_RST;
      s_r.rx_prev  <= utc_pkg::LINE_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  // *****************************************************************
  // outputs
  // *****************************************************************
  assign rx_data           = s_r.fifo[0][7:0];
  assign rx_ninth_bit      = s_r.fifo[0][8];
  assign tx_buf_empty_flag = s_r.tx_empty;
  assign tx_idle_flag      = s_r.tx_idle;
  assign rx_avail_flag     = (s_r.rx_cnt != 2'd0);
  assign rx_idle_flag      = s_r.rx_idle;
  assign overrun_flag      = s_r.ovr;
  assign framing_err_flag  = s_r.fe;
  assign parity_err_flag   = s_r.pe;
  assign noise_flag        = s_r.nf;
  assign tx_irq            = tx_empty_irq_en & s_r.tx_empty;
  assign rx_irq            = s_r.rx_irq;
  assign tx_pin_o          = s_r.tx_line;
  // pin released to its shared function when either enable drops
  assign tx_pin_oe         = serial_func_en & tx_enable;
endmodule // utc_core

// ### design/utc_pkg.sv
// constants and types shared by the serial transmit/receive core
// *****************************************************************
// How it works
// - word length bit selects 9-bit words; ninth bit comes from tx_ninth_bit
// - shift register reloads after the stop bits or while idle, and only if data is pending
// - sending starts with enable set and buffer loaded, on a baud tick or at once on a write while idle
// - clearing tx_enable stops and resets the transmitter and releases the pin
// - data bits leave least significant bit first
// - empty and idle flags clear only by status access then buffer write
// - buffer writes are refused while the buffer-empty flag is zero
// - buffer-empty flag shows room; with its enable it requests an interrupt
// - write while idle goes straight to shifter; write mid-frame waits
// - transmit-idle flag sets when stop bits or a break frame end
// - break sends start then 13-bit zero groups, then one or two stop bits
// - a break raises no transmit interrupt
// - in 9-bit mode the top received bit goes to rx_ninth_bit
// - receiver runs at 16x baud with three-sample majority vote
// - after the stop sample the word moves into the receive buffer if room
// - two words buffered; a third arriving when full is dropped, overrun set
// - with rx_enable set the receiver hunts for a start bit
// - receive-available follows buffer contents; irq on each transfer and overrun
// - receive-available clears only by status access then buffer read, or by clearing serial_func_en
// - break ends after data bits plus one stop; zeros stored, error and idle set
// - after a low stop, wait for a high line before hunting again
// - receive-idle is low from start detection until the stop sample
// - transmitter sends one or two stop bits; receiver checks only one
// - optional odd or even parity replaces the top data bit
// - enabled and not sending, the transmit pin is driven high
// *****************************************************************
package utc_pkg;

  localparam int          OVERSAMPLE   = 16;
  localparam logic [3:0]  TICK_LAST    = 4'hf;
  localparam logic [3:0]  VOTE_FIRST   = 4'h7;
  localparam logic [3:0]  VOTE_LAST    = 4'h9;
  localparam logic [3:0]  BREAK_LAST   = 4'hc;
  localparam logic [3:0]  BITS_SHORT   = 4'h8;
  localparam logic [3:0]  BITS_LONG    = 4'h9;
  localparam logic        TX_EMPTY_RST = 1'b1;
  localparam logic        TX_IDLE_RST  = 1'b1;
  localparam logic        RX_IDLE_RST  = 1'b1;
  localparam logic        LINE_IDLE    = 1'b1;

  typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_BRK, TX_STOP} utc_tx_st_t;
  typedef enum logic [2:0] {RX_HUNT, RX_START, RX_DATA, RX_STOP, RX_WAIT} utc_rx_st_t;

endpackage

// ### sim/utc_core_monitor.sv
// checker for the serial core ports
`timescale 1ns/1ns
module utc_core_monitor #(
  parameter int DIV_W = 8
) (
  input wire logic             clock,
  input wire logic             reset_n,
  input wire logic             serial_func_en,
  input wire logic             tx_enable,
  input wire logic             tx_empty_irq_en,
  input wire logic             rx_irq_en,
  input wire logic [DIV_W-1:0] baud_divisor,
  input wire logic             tx_wr,
  input wire logic             rx_rd,
  input wire logic             rx_pin,
  input wire logic             tx_buf_empty_flag,
  input wire logic             tx_idle_flag,
  input wire logic             rx_avail_flag,
  input wire logic             rx_idle_flag,
  input wire logic             overrun_flag,
  input wire logic             tx_irq,
  input wire logic             rx_irq,
  input wire logic             tx_pin_o,
  input wire logic             tx_pin_oe
);
  // ***************************************
  // properties
  // ***************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // fixed-length checks only hold at the fastest divisor
  sequence s_frame_go;
    $fell(tx_idle_flag) && tx_enable && baud_divisor == '0;
  endsequence
  sequence s_start_low;
    (!tx_pin_o) [*8];
  endsequence
  sequence s_hunt_hit;
    $fell(rx_idle_flag) && baud_divisor == '0;
  endsequence
  a_oe_follows_en: assert property (tx_pin_oe == (serial_func_en && tx_enable))
    else $error("tx output enable mismatch");
  a_start_bit_low: assert property (s_frame_go |-> s_start_low)
    else $error("start bit not low");
  a_abort_line_high: assert property (!tx_enable |=> tx_pin_o)
    else $error("tx line not high while disabled");
  a_tx_irq_level: assert property (tx_irq == (tx_empty_irq_en && tx_buf_empty_flag))
    else $error("tx irq level mismatch");
  a_empty_fall_cause: assert property ($fell(tx_buf_empty_flag) |->
    $past(tx_wr, 1) || $past(tx_wr, 2) || $past(tx_wr, 3))
    else $error("buffer empty flag fell without write");
  a_rx_idle_start: assert property (s_hunt_hit |-> !rx_pin && !$past(rx_pin))
    else $error("rx idle fell without low line");
  a_avail_fall_cause: assert property ($fell(rx_avail_flag) |->
    $past(rx_rd, 1) || $past(rx_rd, 2) || $past(rx_rd, 3) || !$past(serial_func_en))
    else $error("rx avail fell without read");
  a_rx_irq_pulse: assert property (rx_irq |-> $past(rx_irq_en) ##1 !rx_irq)
    else $error("rx irq not a gated pulse");
  a_overrun_full: assert property ($rose(overrun_flag) |-> rx_avail_flag)
    else $error("overrun with room in buffer");
endmodule // utc_core_monitor

bind utc_core utc_core_monitor #(.DIV_W(DIV_W)) utc_core_monitor_inst (
  .clock(clock), .reset_n(reset_n), .serial_func_en(serial_func_en), .tx_enable(tx_enable),
  .tx_empty_irq_en(tx_empty_irq_en), .rx_irq_en(rx_irq_en), .baud_divisor(baud_divisor),
  .tx_wr(tx_wr), .rx_rd(rx_rd), .rx_pin(rx_pin), .tx_buf_empty_flag(tx_buf_empty_flag),
  .tx_idle_flag(tx_idle_flag), .rx_avail_flag(rx_avail_flag), .rx_idle_flag(rx_idle_flag),
  .overrun_flag(overrun_flag), .tx_irq(tx_irq), .rx_irq(rx_irq), .tx_pin_o(tx_pin_o),
  .tx_pin_oe(tx_pin_oe));

// ### sim/utc_peer.sv
// remote serial peer: frame sender and line watcher, one bit is 16 clocks
`timescale 1ns/1ns
module utc_peer (
  input  wire logic       clock,
  input  wire logic       tx_line,
  input  wire logic [3:0] nbits,
  output logic            rx_line,
  output logic [8:0]      got,
  output int              got_cnt
);
  int         j;
  logic [8:0] sh;
  initial begin
    rx_line = 1'b1;
    got = 9'h000;
    got_cnt = 0;
  end
  // ***************************************
  // sender
  // ***************************************
  task automatic send(input logic [8:0] w, input int n, input logic stop_lvl, input logic brk);
    int i;
    @(negedge clock);
    rx_line = 1'b0;
    repeat (16) @(negedge clock);
    for (i = 0; i < (brk ? 13 : n); i++) begin
      rx_line = brk ? 1'b0 : w[i];
      repeat (16) @(negedge clock);
    end
    rx_line = stop_lvl;
    repeat (16) @(negedge clock);
    rx_line = 1'b1;
    repeat (32) @(negedge clock);
  endtask
  // ***************************************
  // watcher, samples mid-bit
  // ***************************************
  always begin
    @(negedge tx_line);
    repeat (8) @(posedge clock);
    sh = 9'h000;
    for (j = 0; j < nbits; j++) begin
      repeat (16) @(posedge clock);
      sh[j] = tx_line;
    end
    got = sh;
    got_cnt++;
  end
endmodule // utc_peer

// ### sim/utc_core_tb.sv
// self-checking bench for the serial core
`timescale 1ns/1ns
module utc_core_tb;
  logic       clock, reset_n, serial_func_en, tx_enable, rx_enable, word_len_sel;
  logic       parity_en, parity_type_sel, stop_count_sel, tx_break_ctrl, tx_ninth_bit;
  logic       tx_empty_irq_en, rx_irq_en, status_rd, tx_wr, rx_rd, rx_ninth_bit, rx_pin;
  logic       tx_buf_empty_flag, tx_idle_flag, rx_avail_flag, rx_idle_flag, overrun_flag;
  logic       framing_err_flag, parity_err_flag, noise_flag, tx_irq, rx_irq, tx_pin_o, tx_pin_oe;
  logic [7:0] baud_divisor, tx_wdata, rx_data;
  logic [8:0] got;
  int         got_cnt, fail_count, n_tests, cyc;
  // released line floats to the pull-up level
  wire        tx_line = tx_pin_oe ? tx_pin_o : 1'b1;
  utc_core #(.DIV_W(8)) utc_core_inst (
    .clock(clock), .reset_n(reset_n), .serial_func_en(serial_func_en), .tx_enable(tx_enable),
    .rx_enable(rx_enable), .word_len_sel(word_len_sel), .parity_en(parity_en),
    .parity_type_sel(parity_type_sel), .stop_count_sel(stop_count_sel), .tx_break_ctrl(tx_break_ctrl),
    .tx_ninth_bit(tx_ninth_bit), .tx_empty_irq_en(tx_empty_irq_en), .rx_irq_en(rx_irq_en),
    .baud_divisor(baud_divisor), .status_rd(status_rd), .tx_wr(tx_wr), .tx_wdata(tx_wdata),
    .rx_rd(rx_rd), .rx_data(rx_data), .rx_ninth_bit(rx_ninth_bit), .tx_buf_empty_flag(tx_buf_empty_flag),
    .tx_idle_flag(tx_idle_flag), .rx_avail_flag(rx_avail_flag), .rx_idle_flag(rx_idle_flag),
    .overrun_flag(overrun_flag), .framing_err_flag(framing_err_flag), .parity_err_flag(parity_err_flag),
    .noise_flag(noise_flag), .tx_irq(tx_irq), .rx_irq(rx_irq), .rx_pin(rx_pin), .tx_pin_o(tx_pin_o),
    .tx_pin_oe(tx_pin_oe));
  utc_peer utc_peer_inst (.clock(clock), .tx_line(tx_line), .nbits(word_len_sel ? 4'h9 : 4'h8),
    .rx_line(rx_pin), .got(got), .got_cnt(got_cnt));
  // ***************************************
  // helpers
  // ***************************************
  always #20 clock = ~clock;
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      fail_count++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock);
  endtask
  // status access, then a buffer write or read
  task automatic sw(input logic is_wr, input logic [8:0] d);
    tick(1);
    status_rd = 1'b1;
    tick(1);
    status_rd = 1'b0;
    tx_wr = is_wr;
    rx_rd = !is_wr;
    {tx_ninth_bit, tx_wdata} = d;
    tick(1);
    tx_wr = 1'b0;
    rx_rd = 1'b0;
    tick(1);
  endtask
  task automatic wait_got(input int n);
    for (int k = 0; k < 3000 && got_cnt < n; k++) tick(1);
  endtask
  function automatic logic [8:0] frame_word(input logic [8:0] w);
    logic [8:0] r;
    r = word_len_sel ? w : {1'b0, w[7:0]};
    if (parity_en && word_len_sel) r[8] = ^r[7:0] ^ parity_type_sel;
    else if (parity_en) r[7] = ^r[6:0] ^ parity_type_sel;
    return r;
  endfunction
  // ***************************************
  // sequence
  // ***************************************
  initial begin
    int i, c, n;
    logic [8:0] a, b;
    {clock, reset_n, serial_func_en, tx_enable, rx_enable, word_len_sel, parity_en} = '0;
    {parity_type_sel, stop_count_sel, tx_break_ctrl, tx_ninth_bit, tx_empty_irq_en} = '0;
    {rx_irq_en, status_rd, tx_wr, rx_rd, baud_divisor, tx_wdata} = '0;
    {fail_count, n_tests, cyc} = '0;
    void'($urandom(32'hda598eb8));
    tick(12);
    reset_n = 1'b1;
    check(16'({tx_buf_empty_flag, tx_idle_flag, rx_idle_flag, rx_avail_flag, tx_pin_o}), 16'h1d);
    {serial_func_en, tx_empty_irq_en, rx_irq_en, rx_enable} = 4'hf;
    tx_wr = 1'b1;
    tick(1);
    tx_wr = 1'b0;
    check(16'(tx_buf_empty_flag), 16'h1);
    sw(1'b1, 9'h05a);
    c = got_cnt;
    tick(100);
    check(16'(got_cnt), 16'(c));
    tx_enable = 1'b1;
    wait_got(c + 1);
    check(16'(got), 16'h05a);
    sw(1'b1, 9'h0c3);
    tick(60);
    tx_enable = 1'b0;
    tick(2);
    check(16'({tx_pin_oe, tx_pin_o}), 16'h1);
    tick(300);
    tx_enable = 1'b1;
    for (i = 0; i < 6; i++) begin
      {word_len_sel, parity_en, parity_type_sel} = {i[0], i > 3, i[1] ^ i[0]};
      stop_count_sel = 1'($urandom);
      a = (i == 0) ? 9'h1ff : 9'($urandom);
      b = (i == 0) ? 9'h000 : 9'($urandom);
      c = got_cnt;
      sw(1'b1, a);
      sw(1'b1, b);
      check(16'({tx_irq, tx_buf_empty_flag}), 16'h0);
      sw(1'b1, ~b);
      wait_got(c + 1);
      check(16'(got), 16'(frame_word(a)));
      wait_got(c + 2);
      check(16'(got), 16'(frame_word(b)));
      tick(400);
      check(16'({got_cnt[3:0], tx_idle_flag, tx_buf_empty_flag}), 16'({4'(c + 2), 2'h3}));
    end
    {word_len_sel, parity_en, stop_count_sel} = 3'h0;
    tx_break_ctrl = 1'b1;
    for (c = 0; c < 500 && tx_line; c++) tick(1);
    for (n = 0; n < 2000 && !tx_line; n++) begin
      tick(1);
      if (n == 20) tx_break_ctrl = 1'b0;
    end
    check(16'(n), 16'h00e0);
    tick(64);
    check(16'({tx_idle_flag, tx_buf_empty_flag}), 16'h3);
    for (i = 0; i < 3; i++) utc_peer_inst.send(9'h0a0 + 9'(i), 8, 1'b1, 1'b0);
    check(16'({overrun_flag, rx_avail_flag, rx_data}), 16'h3a0);
    sw(1'b0, 9'h000);
    check(16'(rx_data), 16'h00a1);
    sw(1'b0, 9'h000);
    check(16'(rx_avail_flag), 16'h0);
    word_len_sel = 1'b1;
    a = 9'($urandom);
    utc_peer_inst.send(a, 9, 1'b1, 1'b0);
    check(16'({rx_ninth_bit, rx_data}), 16'(a));
    sw(1'b0, 9'h000);
    {word_len_sel, parity_en, parity_type_sel} = 3'h2;
    utc_peer_inst.send(9'h001, 8, 1'b1, 1'b0);
    check(16'(parity_err_flag), 16'h1);
    sw(1'b0, 9'h000);
    parity_en = 1'b0;
    utc_peer_inst.send(9'h0a5, 8, 1'b0, 1'b0);
    check(16'({framing_err_flag, rx_data}), 16'h1a5);
    sw(1'b0, 9'h000);
    utc_peer_inst.send(9'h000, 8, 1'b1, 1'b1);
    check(16'({rx_avail_flag, framing_err_flag, rx_idle_flag, rx_data}), 16'h700);
    sw(1'b0, 9'h000);
    utc_peer_inst.send(9'h03c, 8, 1'b1, 1'b0);
    check(16'({noise_flag, rx_avail_flag, rx_data}), 16'h13c);
    sw(1'b0, 9'h000);
    rx_enable = 1'b0;
    utc_peer_inst.send(9'h055, 8, 1'b1, 1'b0);
    check(16'(rx_avail_flag), 16'h0);
    tally_and_finish();
  end
endmodule // utc_core_tb
